/* rtl/pdsg_regs.svh */
// register offsets, field positions, reset values and counts of the sync generator
`ifndef PDSG_REGS_SVH
`define PDSG_REGS_SVH
// ==========================================================
// register byte offsets
`define PDSG_CTRL_OFS 8'h00
`define PDSG_PRESCALE_OFS 8'h04
`define PDSG_MATCH_OFS 8'h08
`define PDSG_STATUS_OFS 8'h0C
// ==========================================================
// control fields
`define PDSG_CTRL_LEAD_BIT 0
`define PDSG_CTRL_EN_BIT 1
// ==========================================================
// status fields
`define PDSG_STAT_ARMED_BIT 0
`define PDSG_STAT_PCNT_LSB 4
// ==========================================================
// reset values and limits
`define PDSG_CTRL_RST 2'h0
`define PDSG_PRESCALE_RST 4'h1
`define PDSG_PRESCALE_MAX 4'hF
`define PDSG_MATCH_RST 16'h002B
`endif

/* rtl/pdsg_pkg.sv */
// types shared by the sync generator
package pdsg_pkg;
   // ==========================================================
   // axi response codes
   typedef enum logic [1:0] {
      PDSG_RESP_OKAY = 2'h0,
      PDSG_RESP_SLVERR = 2'h2
   } pdsg_resp_t;
endpackage : pdsg_pkg

/* rtl/pdsg_sync_gen.sv */
// ping forwarding, prescaled ping launch and delayed sync-in pulse generator
// Operation
// - lead unit fires transmitter frame-send trigger from compare c event
// - lead compare events pass prescaler; trigger every nth event, n up to 15
// - node waits programmed match count after received ping, then pulses sync-in
// - match count is a per-node setting; 43 first node, 1 second node
// - logic block output drives transmitter external trigger directly
// - received ping immediately triggers forwarding of a ping frame
// - delay counter clears to zero and stops on reaching the match value, until the next ping
`include "pdsg_regs.svh"
module pdsg_sync_gen
   import pdsg_pkg::*;
#(
   parameter int MATCH_W = 16
) (
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic pwm_compare_c_output,
   input wire logic rx_ping_pulse,
   output logic logic_block_output,
   output logic sync_in_pulse,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   // ==========================================================
   // register state
   logic [1:0] ctrl_reg, ctrl_next;
   logic [3:0] presc_reg, presc_next;
   logic [MATCH_W-1:0] match_reg, match_next;
   logic aw_hold_reg, aw_hold_next;
   logic w_hold_reg, w_hold_next;
   logic [7:0] awaddr_reg, awaddr_next;
   logic [31:0] wdata_reg, wdata_next;
   logic [3:0] wstrb_reg, wstrb_next;
   logic bvalid_reg, bvalid_next;
   logic [1:0] bresp_reg, bresp_next;
   logic rvalid_reg, rvalid_next;
   logic [31:0] rdata_reg, rdata_next;
   logic [1:0] rresp_reg, rresp_next;
   // ==========================================================
   // event state
   logic cmp_d_reg, cmp_d_next;
   logic [3:0] pcnt_reg, pcnt_next;
   logic armed_reg, armed_next;
   logic [MATCH_W-1:0] dcnt_reg, dcnt_next;
   logic trig_reg, trig_next;
   logic sync_reg, sync_next;

   // true when the byte offset names a mapped register
   function automatic logic pdsg_mapped(input logic [7:0] a);
      return (a == `PDSG_CTRL_OFS) || (a == `PDSG_PRESCALE_OFS) ||
             (a == `PDSG_MATCH_OFS) || (a == `PDSG_STATUS_OFS);
   endfunction : pdsg_mapped

   logic lead_mode, enable, cmp_rise, match_hit, do_write;
   assign lead_mode = ctrl_reg[`PDSG_CTRL_LEAD_BIT];
   assign enable = ctrl_reg[`PDSG_CTRL_EN_BIT];
   assign cmp_rise = pwm_compare_c_output & ~cmp_d_reg;
   assign match_hit = armed_reg && (dcnt_reg + 1'b1 >= match_reg);
   assign do_write = aw_hold_reg && w_hold_reg && !bvalid_reg;

   // ==========================================================
   // bus slave next state; address and data are taken in either order
   always_comb begin
      ctrl_next = ctrl_reg;
      presc_next = presc_reg;
      match_next = match_reg;
      aw_hold_next = aw_hold_reg;
      w_hold_next = w_hold_reg;
      awaddr_next = awaddr_reg;
      wdata_next = wdata_reg;
      wstrb_next = wstrb_reg;
      bvalid_next = bvalid_reg;
      bresp_next = bresp_reg;
      rvalid_next = rvalid_reg;
      rdata_next = rdata_reg;
      rresp_next = rresp_reg;
      if (s_axi_awvalid && s_axi_awready) begin
         aw_hold_next = 1'b1;
         awaddr_next = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         w_hold_next = 1'b1;
         wdata_next = s_axi_wdata;
         // strobes belong to the beat; the master may move them once taken
         wstrb_next = s_axi_wstrb;
      end
      if (do_write) begin
         aw_hold_next = 1'b0;
         w_hold_next = 1'b0;
         bvalid_next = 1'b1;
         bresp_next = pdsg_mapped(awaddr_reg) ? PDSG_RESP_OKAY
                                              : PDSG_RESP_SLVERR;
         // only the low byte lane carries control fields
         if (awaddr_reg == `PDSG_CTRL_OFS && wstrb_reg[0])
            ctrl_next = wdata_reg[1:0];
         // prescaler takes the low four bits; a zero write is stored and read as one
         if (awaddr_reg == `PDSG_PRESCALE_OFS && wstrb_reg[0])
            presc_next = (wdata_reg[3:0] == 4'h0) ? 4'h1 : wdata_reg[3:0];
         if (awaddr_reg == `PDSG_MATCH_OFS) begin
            if (wstrb_reg[0])
               match_next[7:0] = wdata_reg[7:0];
            if (wstrb_reg[1])
               match_next[MATCH_W-1:8] = wdata_reg[MATCH_W-1:8];
         end
      end
      if (bvalid_reg && s_axi_bready)
         bvalid_next = 1'b0;
      if (s_axi_arvalid && s_axi_arready) begin
         rvalid_next = 1'b1;
         rresp_next = pdsg_mapped(s_axi_araddr) ? PDSG_RESP_OKAY
                                                : PDSG_RESP_SLVERR;
         unique case (s_axi_araddr)
            `PDSG_CTRL_OFS: rdata_next = {30'h0, ctrl_reg};
            `PDSG_PRESCALE_OFS: rdata_next = {28'h0, presc_reg};
            `PDSG_MATCH_OFS: rdata_next = {{(32-MATCH_W){1'b0}}, match_reg};
            `PDSG_STATUS_OFS: rdata_next = {24'h0, pcnt_reg, 3'h0, armed_reg};
            default: rdata_next = 32'h0;
         endcase
      end else if (rvalid_reg && s_axi_rready) begin
         rvalid_next = 1'b0;
      end
   end

   // bus slave registers
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         ctrl_reg <= `PDSG_CTRL_RST;
         presc_reg <= `PDSG_PRESCALE_RST;
         match_reg <= `PDSG_MATCH_RST;
         aw_hold_reg <= 1'b0;
         w_hold_reg <= 1'b0;
         awaddr_reg <= 8'h00;
         wdata_reg <= 32'h0;
         wstrb_reg <= 4'h0;
         bvalid_reg <= 1'b0;
         bresp_reg <= 2'h0;
         rvalid_reg <= 1'b0;
         rdata_reg <= 32'h0;
         rresp_reg <= 2'h0;
      end else begin
         ctrl_reg <= ctrl_next;
         presc_reg <= presc_next;
         match_reg <= match_next;
         aw_hold_reg <= aw_hold_next;
         w_hold_reg <= w_hold_next;
         awaddr_reg <= awaddr_next;
         wdata_reg <= wdata_next;
         wstrb_reg <= wstrb_next;
         bvalid_reg <= bvalid_next;
         bresp_reg <= bresp_next;
         rvalid_reg <= rvalid_next;
         rdata_reg <= rdata_next;
         rresp_reg <= rresp_next;
      end
   end

   // handshake outputs; one write and one read in flight at most
   assign s_axi_awready = !aw_hold_reg && !bvalid_reg;
   assign s_axi_wready = !w_hold_reg && !bvalid_reg;
   assign s_axi_bvalid = bvalid_reg;
   assign s_axi_bresp = bresp_reg;
   assign s_axi_arready = !rvalid_reg;
   assign s_axi_rvalid = rvalid_reg;
   assign s_axi_rdata = rdata_reg;
   assign s_axi_rresp = rresp_reg;

   // ==========================================================
   // event logic next state
   always_comb begin
      cmp_d_next = pwm_compare_c_output;
      pcnt_next = pcnt_reg;
      armed_next = armed_reg;
      dcnt_next = dcnt_reg;
      trig_next = 1'b0;
      sync_next = 1'b0;
      if (!enable) begin
         pcnt_next = 4'h0;
         armed_next = 1'b0;
         dcnt_next = '0;
      end else if (lead_mode) begin
         // compare c edge counts toward a launch
         if (cmp_rise) begin
            // fire on every nth compare event
            if (pcnt_reg + 1'b1 >= presc_reg) begin
               pcnt_next = 4'h0;
               trig_next = 1'b1;
            end else begin
               pcnt_next = pcnt_reg + 1'b1;
            end
         end
      end else begin
         trig_next = rx_ping_pulse;
         if (armed_reg) begin
            dcnt_next = dcnt_reg + 1'b1;
         end
         if (match_hit) begin
            dcnt_next = '0;
            // match ends the delay with a sync-in pulse
            sync_next = 1'b1;
            armed_next = 1'b0;
         end
         // a ping arriving with the match re-arms: set wins
         if (rx_ping_pulse) begin
            armed_next = 1'b1;
            if (!armed_reg || match_hit)
               dcnt_next = '0;
         end
      end
   end

   // event logic registers
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         cmp_d_reg <= 1'b0;
         pcnt_reg <= 4'h0;
         armed_reg <= 1'b0;
         dcnt_reg <= '0;
         trig_reg <= 1'b0;
         sync_reg <= 1'b0;
      end else begin
         cmp_d_reg <= cmp_d_next;
         pcnt_reg <= pcnt_next;
         armed_reg <= armed_next;
         dcnt_reg <= dcnt_next;
         trig_reg <= trig_next;
         sync_reg <= sync_next;
      end
   end

   // trigger goes straight to the transmitter
   assign logic_block_output = trig_reg;
   assign sync_in_pulse = sync_reg;
endmodule : pdsg_sync_gen

/* sim/pdsg_sync_gen_chk.sv */
// port checker for the sync generator
// ==========================================================
// checker
module pdsg_sync_gen_chk (
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic pwm_compare_c_output,
   input wire logic rx_ping_pulse,
   input wire logic logic_block_output,
   input wire logic sync_in_pulse,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   timeunit 1ns;
   timeprecision 1ns;
   logic seen_reg;
   logic seen_next;
   // remembers a ping that has not yet produced its sync
   always_comb begin
      seen_next = rx_ping_pulse | (seen_reg & ~sync_in_pulse);
   end
   always_ff @(posedge clock) begin
      seen_reg <= sys_rst ? 1'b0 : seen_next;
   end
   default clocking @(posedge clock); endclocking
   default disable iff (sys_rst);
   trig_pulse_a: assert property (
      logic_block_output |=> !logic_block_output) else $error("trigger wide");
   // trigger follows a ping or a compare rise
   trig_cause_a: assert property (
      logic_block_output |-> $past(rx_ping_pulse)
         || ($past(pwm_compare_c_output)
         && !$past(pwm_compare_c_output, 2))) else $error("trigger uncaused");
   sync_pulse_a: assert property (
      sync_in_pulse |=> !sync_in_pulse) else $error("sync wide");
   sync_armed_a: assert property (
      sync_in_pulse |-> seen_reg) else $error("sync without ping");
   b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("bvalid dropped");
   rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=>
      s_axi_rvalid) else $error("read late");
   r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
      else $error("rvalid dropped");
   ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("arready during rvalid");
   cover property (sync_in_pulse);
   cover property (logic_block_output && $past(pwm_compare_c_output)
      && !$past(pwm_compare_c_output, 2));
   cover property (logic_block_output && $past(rx_ping_pulse));
endmodule : pdsg_sync_gen_chk
bind pdsg_sync_gen pdsg_sync_gen_chk u_chk (.clock(clock), .sys_rst(sys_rst),
   .pwm_compare_c_output(pwm_compare_c_output), .rx_ping_pulse(rx_ping_pulse),
   .logic_block_output(logic_block_output), .sync_in_pulse(sync_in_pulse),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

/* sim/pdsg_far_end.sv */
// far-side model: compare c source and ping receiver
// ==========================================================
// model
module pdsg_far_end (
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic pwm_run,
   input wire logic ping_req,
   output logic pwm_compare_c_output,
   output logic rx_ping_pulse
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [1:0] ph_reg;
   // four-cycle period; idle timer keeps compare low
   always_ff @(posedge clock) begin
      ph_reg <= (sys_rst | ~pwm_run) ? 2'h0 : ph_reg + 2'h1;
      rx_ping_pulse <= ~sys_rst & ping_req;
   end
   assign pwm_compare_c_output = ph_reg[1];
endmodule : pdsg_far_end

/* sim/ping_delayed_sync_gen_test.sv */
// self-checking bench of the sync generator
`include "pdsg_regs.svh"
module ping_delayed_sync_gen_test import pdsg_pkg::*;;
   timeunit 1ns;
   timeprecision 1ns;
   logic clock, sys_rst, pwm_run, ping_req, pwm, rx, lbo, sync;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp, wr_resp;
   logic awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready;
   int err_count, compares;
   pdsg_far_end far (.clock(clock), .sys_rst(sys_rst), .pwm_run(pwm_run),
      .ping_req(ping_req), .pwm_compare_c_output(pwm), .rx_ping_pulse(rx));
   pdsg_sync_gen dut (.clock(clock), .sys_rst(sys_rst),
      .pwm_compare_c_output(pwm), .rx_ping_pulse(rx),
      .logic_block_output(lbo), .sync_in_pulse(sync),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready));
   always #25 clock = ~clock;
   task chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   // readies sampled mid-cycle so the release edge is never raced
   task wr(input logic [7:0] a, input logic [31:0] d);
      logic aw, w, b;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      b = 1'b0;
      while (!b) begin
         @(negedge clock);
         aw = awvalid & awready;
         w = wvalid & wready;
         b = bvalid;
         wr_resp = bresp;
         @(posedge clock);
         if (aw) awvalid <= 1'b0;
         if (w) wvalid <= 1'b0;
      end
      bready <= 1'b0;
      @(posedge clock);
   endtask : wr
   task rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      logic ar, v;
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      v = 1'b0;
      while (!v) begin
         @(negedge clock);
         ar = arready;
         v = rvalid;
         d = rdata;
         r = rresp;
         @(posedge clock);
         if (ar) arvalid <= 1'b0;
      end
      rready <= 1'b0;
      @(posedge clock);
   endtask : rd
   task reset_regs;
      logic [31:0] d;
      logic [1:0] r;
      rd(`PDSG_CTRL_OFS, d, r);
      chk(d, 32'h0);
      rd(`PDSG_PRESCALE_OFS, d, r);
      chk(d, 32'h1);
      rd(`PDSG_MATCH_OFS, d, r);
      chk(d, 32'h2B);
      rd(`PDSG_STATUS_OFS, d, r);
      chk({d[31:2], r}, {30'h0, PDSG_RESP_OKAY});
      rd(8'h10, d, r);
      chk({d[31:2], r}, {30'h0, PDSG_RESP_SLVERR});
   endtask : reset_regs
   // byte lanes and write responses; only lane 0 of match is written
   task strobe_lanes;
      logic [31:0] d;
      logic [1:0] r;
      wstrb <= 4'h1;
      wr(`PDSG_MATCH_OFS, 32'h0000_5A07);
      wstrb <= 4'hF;
      chk({30'h0, wr_resp}, {30'h0, PDSG_RESP_OKAY});
      rd(`PDSG_MATCH_OFS, d, r);
      chk(d, 32'h0000_0007);
      wr(8'h10, 32'hFFFF_FFFF);
      chk({30'h0, wr_resp}, {30'h0, PDSG_RESP_SLVERR});
      rd(`PDSG_CTRL_OFS, d, r);
      chk(d, 32'h0);
   endtask : strobe_lanes
   task node_delay(input logic [15:0] m);
      int n;
      wr(`PDSG_MATCH_OFS, {16'h0, m});
      wr(`PDSG_CTRL_OFS, 32'h2);
      ping_req <= 1'b1;
      @(posedge clock);
      ping_req <= 1'b0;
      @(posedge clock);
      n = 0;
      @(negedge clock);
      chk({31'h0, lbo}, 32'h1);
      while (sync !== 1'b1 && n < 2000) begin
         n++;
         @(negedge clock);
      end
      chk(n, {16'h0, m});
      @(posedge clock);
      wr(`PDSG_CTRL_OFS, 32'h0);
   endtask : node_delay
   task lead_prescale(input logic [3:0] p);
      int n;
      wr(`PDSG_PRESCALE_OFS, {28'h0, p});
      wr(`PDSG_CTRL_OFS, 32'h3);
      pwm_run <= 1'b1;
      n = 0;
      for (int k = 0; k < 8 * p + 1; k++) begin
         @(negedge clock);
         if (lbo === 1'b1) n++;
      end
      @(posedge clock);
      pwm_run <= 1'b0;
      chk(n, 32'h2);
      wr(`PDSG_CTRL_OFS, 32'h0);
   endtask : lead_prescale
   task end_sim;
      $display("errors %0d compares %0d", err_count, compares);
      if (err_count == 0 && compares > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : end_sim
   initial begin
      repeat (6000) @(posedge clock);
      err_count++;
      end_sim();
   end
   initial begin
      {clock, pwm_run, ping_req, awvalid, wvalid, bready} = 6'h00;
      {arvalid, rready, awaddr, araddr, wdata} = 50'h0;
      wstrb = 4'hF;
      sys_rst = 1'b1;
      repeat (8) @(posedge clock);
      sys_rst <= 1'b0;
      @(posedge clock);
      reset_regs();
      strobe_lanes();
      node_delay(16'h002B);
      node_delay(16'h0001);
      lead_prescale(4'h1);
      lead_prescale(4'hF);
      end_sim();
   end
endmodule : ping_delayed_sync_gen_test
